//--- src/dpm_pkg.sv
package dpm_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int unsigned N_PORTS      = 4;
  localparam int unsigned N_MAP_REGS   = 3;
  localparam int unsigned PRIO_W       = 2;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned DATA_W       = 8;

  //////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_MAP_34_37 = 8'h9D;
  localparam logic [7:0] ADDR_MAP_38_3B = 8'h9E;
  localparam logic [7:0] ADDR_MAP_3C_3F = 8'h9F;
  localparam logic [7:0] ADDR_P1_CTRL8  = 8'hC0;
  localparam logic [7:0] ADDR_P2_CTRL8  = 8'hD0;
  localparam logic [7:0] ADDR_P3_CTRL8  = 8'hE0;
  localparam logic [7:0] ADDR_P4_CTRL8  = 8'hF0;

  localparam logic [N_MAP_REGS-1:0][7:0] MAP_ADDR =
    {ADDR_MAP_3C_3F, ADDR_MAP_38_3B, ADDR_MAP_34_37};
  localparam logic [N_PORTS-1:0][7:0] CTRL8_ADDR =
    {ADDR_P4_CTRL8, ADDR_P3_CTRL8, ADDR_P2_CTRL8, ADDR_P1_CTRL8};

  //////////////////////////////////////////////////////////////////////////////
  // Fields and reset values
  localparam int unsigned BIT_INS_HIGH   = 3;
  localparam int unsigned BIT_INS_SECOND = 2;
  localparam logic [7:0]  MAP_RST        = 8'h00;
  localparam logic [1:0]  INS_RST        = 2'h0;
  localparam logic [5:0]  DSCP_FIRST     = 6'h34;
  localparam int unsigned DSCP_LSB       = 2;

  // Egress index (0 = port 1) per source index
  localparam logic [N_PORTS-1:0][1:0] DEST_HIGH   = {2'h2, 2'h3, 2'h3, 2'h3};
  localparam logic [N_PORTS-1:0][1:0] DEST_SECOND = {2'h1, 2'h1, 2'h2, 2'h2};

  //////////////////////////////////////////////////////////////////////////////
  // State carrier
  typedef struct packed {
    logic [N_MAP_REGS-1:0][7:0]      map;
    logic [N_PORTS-1:0][1:0]         ins;
    logic [7:0]                      rdata;
    logic                            rvalid;
    logic [1:0]                      prio;
    logic                            prio_hit;
    logic                            prio_valid;
    logic [N_PORTS-1:0][N_PORTS-1:0] ins_mat;
  } dpm_state_s;

  localparam dpm_state_s DPM_STATE_RST = '0;

endpackage : dpm_pkg

//--- src/dpm_vid_route.sv
`timescale 1ns/1ps
module dpm_vid_route
  import dpm_pkg::*;
(
  input  wire logic                            glob_en,
  input  wire logic [N_PORTS-1:0][1:0]         ins,
  output logic      [N_PORTS-1:0][N_PORTS-1:0] ins_mat
);

  // One row per source port, one bit per egress port
  for (genvar g = 0; g < N_PORTS; g++) begin : g_src
    logic [N_PORTS-1:0] high_bit;
    logic [N_PORTS-1:0] second_bit;
    assign high_bit   = N_PORTS'(1) << DEST_HIGH[g];
    assign second_bit = N_PORTS'(1) << DEST_SECOND[g];
    assign ins_mat[g] = ({N_PORTS{glob_en & ins[g][1]}} & high_bit)
                      | ({N_PORTS{glob_en & ins[g][0]}} & second_bit);
  end

endmodule : dpm_vid_route

//--- src/dpm_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Register 0x9D holds priorities of code points 0x34..0x37, two bits each.
// - Register 0x9E holds priorities of code points 0x38..0x3B, two bits each.
// - Register 0x9F holds priorities of code points 0x3C..0x3F, two bits each.
// - All priority fields read/write, reset to 00, shared by IPv4 and IPv6.
// - Control-8 bit 3 inserts source default VID toward highest other port.
// - Control-8 bit 2 inserts source default VID toward second-highest port.
// - Insertion bits act only with global enable set; they reset to 0.
// - Control-8 at 0xC0/0xD0/0xE0/0xF0; bits 7-4 read zero.
module dpm_top
  import dpm_pkg::*;
(
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  input  wire logic [ADDR_W-1:0]               reg_addr,
  input  wire logic                            reg_wr,
  input  wire logic [DATA_W-1:0]               reg_wdata,
  input  wire logic                            reg_rd,
  output logic      [DATA_W-1:0]               reg_rdata,
  output logic                                 reg_rvalid,
  input  wire logic                            glob_vid_insert_en,
  input  wire logic [7:0]                      pkt_ds_byte,
  input  wire logic                            pkt_valid,
  output logic      [PRIO_W-1:0]               pkt_prio,
  output logic                                 pkt_prio_hit,
  output logic                                 pkt_prio_valid,
  output logic      [N_PORTS-1:0][N_PORTS-1:0] vid_insert
);

  dpm_state_s                      s_reg;
  dpm_state_s                      s_next;
  logic [N_PORTS-1:0][N_PORTS-1:0] ins_mat;
  logic [5:0]                      code_pt;
  logic [5:0]                      entry;

  //////////////////////////////////////////////////////////////////////////////
  // Insertion routing
  dpm_vid_route u_route (
    .glob_en (glob_vid_insert_en),
    .ins     (s_reg.ins),
    .ins_mat (ins_mat)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_next            = s_reg;
    s_next.rvalid     = 1'b0;
    s_next.prio_valid = 1'b0;
    s_next.ins_mat    = ins_mat;
    code_pt           = pkt_ds_byte[7:DSCP_LSB];
    entry             = code_pt - DSCP_FIRST;

    // Register writes
    if (reg_wr) begin
      for (int i = 0; i < N_MAP_REGS; i++) begin
        if (reg_addr == MAP_ADDR[i]) begin
          s_next.map[i] = reg_wdata;
        end
      end
      for (int p = 0; p < N_PORTS; p++) begin
        if (reg_addr == CTRL8_ADDR[p]) begin
          s_next.ins[p] = {reg_wdata[BIT_INS_HIGH],
                           reg_wdata[BIT_INS_SECOND]};
        end
      end
    end

    // Register reads; unmapped offsets read zero
    if (reg_rd) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = 8'h00;
      for (int i = 0; i < N_MAP_REGS; i++) begin
        if (reg_addr == MAP_ADDR[i]) begin
          s_next.rdata = s_reg.map[i];
        end
      end
      for (int p = 0; p < N_PORTS; p++) begin
        if (reg_addr == CTRL8_ADDR[p]) begin
          s_next.rdata[BIT_INS_HIGH]   = s_reg.ins[p][1];
          s_next.rdata[BIT_INS_SECOND] = s_reg.ins[p][0];
        end
      end
    end

    // Code point lookup; entries below this slice report no hit
    if (pkt_valid) begin
      s_next.prio_valid = 1'b1;
      if (code_pt >= DSCP_FIRST) begin
        s_next.prio_hit = 1'b1;
        s_next.prio     = s_reg.map[entry[3:2]][{entry[1:0], 1'b0} +: 2];
      end else begin
        s_next.prio_hit = 1'b0;
        s_next.prio     = 2'h0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_reg <= DPM_STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata      = s_reg.rdata;
  assign reg_rvalid     = s_reg.rvalid;
  assign pkt_prio       = s_reg.prio;
  assign pkt_prio_hit   = s_reg.prio_hit;
  assign pkt_prio_valid = s_reg.prio_valid;
  assign vid_insert     = s_reg.ins_mat;

endmodule : dpm_top

//--- tb/dpm_top_sva.sv
`timescale 1ns/1ps
module dpm_top_sva
  import dpm_pkg::*;
(
  input wire logic                            core_clk,
  input wire logic                            rst,
  input wire logic [ADDR_W-1:0]               reg_addr,
  input wire logic                            reg_rd,
  input wire logic [DATA_W-1:0]               reg_rdata,
  input wire logic                            reg_rvalid,
  input wire logic                            glob_vid_insert_en,
  input wire logic [7:0]                      pkt_ds_byte,
  input wire logic                            pkt_valid,
  input wire logic [PRIO_W-1:0]               pkt_prio,
  input wire logic                            pkt_prio_hit,
  input wire logic                            pkt_prio_valid,
  input wire logic [N_PORTS-1:0][N_PORTS-1:0] vid_insert
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_RD_ANS: assert property (reg_rd |=> reg_rvalid)
    else $error("read answer missing");
  AST_RD_ONE: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read answer without read");
  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  AST_LK_ANS: assert property (pkt_valid |=> pkt_prio_valid)
    else $error("lookup answer missing");
  AST_LK_ONE: assert property (!pkt_valid |=> !pkt_prio_valid)
    else $error("lookup answer without lookup");
  AST_HIT: assert property (pkt_valid |=>
    pkt_prio_hit == ($past(pkt_ds_byte) >= 8'hD0)) else $error("bad hit");
  AST_MISS: assert property (pkt_valid && pkt_ds_byte < 8'hD0
    |=> pkt_prio == 2'h0) else $error("miss gave priority");
  AST_RSVD: assert property (reg_rd && reg_addr[3:0] == 4'h0
    && reg_addr >= 8'hC0 |=> reg_rdata[7:4] == 4'h0)
    else $error("reserved bits not zero");
  AST_GLOB: assert property (!glob_vid_insert_en |=> vid_insert == '0)
    else $error("insertion without global enable");
  AST_MAP: assert property (glob_vid_insert_en |=>
    (vid_insert & 16'h9533) == 16'h0000)
    else $error("insertion toward a port outside the map");
  cover property (reg_rd ##1 reg_rdata != 8'h00);
  cover property (pkt_valid && pkt_ds_byte >= 8'hD0);
  cover property (glob_vid_insert_en ##1 vid_insert != '0);
endmodule : dpm_top_sva
bind dpm_top dpm_top_sva u_dpm_top_sva (
  .core_clk           (core_clk),
  .rst                (rst),
  .reg_addr           (reg_addr),
  .reg_rd             (reg_rd),
  .reg_rdata          (reg_rdata),
  .reg_rvalid         (reg_rvalid),
  .glob_vid_insert_en (glob_vid_insert_en),
  .pkt_ds_byte        (pkt_ds_byte),
  .pkt_valid          (pkt_valid),
  .pkt_prio           (pkt_prio),
  .pkt_prio_hit       (pkt_prio_hit),
  .pkt_prio_valid     (pkt_prio_valid),
  .vid_insert         (vid_insert)
);

//--- tb/dscp_priority_map_upper_bench.sv
`timescale 1ns/1ps
module dscp_priority_map_upper_bench;
  import dpm_pkg::*;
  logic core_clk = 1'h0, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic glob_vid_insert_en = 1'h0, pkt_valid = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, pkt_ds_byte = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rvalid, pkt_prio_hit, pkt_prio_valid;
  logic [1:0] pkt_prio;
  logic [3:0][3:0] vid_insert;
  int err_total = 0;
  int tests_run = 0;
  localparam logic [2:0][7:0] MV = {8'h9C, 8'h1B, 8'hE4};
  localparam logic [3:0][7:0] CV = {8'hF8, 8'h0C, 8'h04, 8'h08};
  dpm_top u_dpm_top (
    .core_clk           (core_clk),
    .rst                (rst),
    .reg_addr           (reg_addr),
    .reg_wr             (reg_wr),
    .reg_wdata          (reg_wdata),
    .reg_rd             (reg_rd),
    .reg_rdata          (reg_rdata),
    .reg_rvalid         (reg_rvalid),
    .glob_vid_insert_en (glob_vid_insert_en),
    .pkt_ds_byte        (pkt_ds_byte),
    .pkt_valid          (pkt_valid),
    .pkt_prio           (pkt_prio),
    .pkt_prio_hit       (pkt_prio_hit),
    .pkt_prio_valid     (pkt_prio_valid),
    .vid_insert         (vid_insert)
  );
  initial forever #12.5 core_clk = ~core_clk;
  //////////////////////////////////////////////////////////////////////////////
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge core_clk);
    reg_wr = 1'h0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge core_clk);
    reg_rd = 1'h0;
    cmp({reg_rvalid, reg_rdata}, {1'h1, e});
  endtask : rd
  task lk(input logic [7:0] d, input logic [2:0] e);
    @(negedge core_clk);
    pkt_ds_byte = d;
    pkt_valid = 1'h1;
    @(negedge core_clk);
    pkt_valid = 1'h0;
    cmp({pkt_prio_valid, pkt_prio_hit, pkt_prio}, {1'h1, e});
  endtask : lk
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'h0;
    for (int i = 0; i < N_MAP_REGS; i++) rd(MAP_ADDR[i], MAP_RST);
    for (int i = 0; i < N_PORTS; i++) rd(CTRL8_ADDR[i], 8'h00);
    $display("reset test done");
    for (int i = 0; i < N_MAP_REGS; i++) wr(MAP_ADDR[i], MV[i]);
    for (int i = 0; i < N_MAP_REGS; i++) rd(MAP_ADDR[i], MV[i]);
    for (int i = 0; i < 12; i++) begin
      lk({6'h34 + 6'(i), 2'(i)}, {1'h1, MV[i/4][2*(i%4)+:2]});
    end
    lk(8'hCF, 3'h0);
    wr(8'hA0, 8'hFF);
    rd(8'hA0, 8'h00);
    $display("map test done");
    for (int i = 0; i < N_PORTS; i++) wr(CTRL8_ADDR[i], CV[i]);
    for (int i = 0; i < N_PORTS; i++) rd(CTRL8_ADDR[i], CV[i] & 8'h0C);
    cmp(vid_insert, 16'h0000);
    glob_vid_insert_en = 1'h1;
    repeat (2) @(negedge core_clk);
    cmp(vid_insert, 16'h4A48);
    glob_vid_insert_en = 1'h0;
    repeat (2) @(negedge core_clk);
    cmp(vid_insert, 16'h0000);
    $display("insert test done");
    // Mid-run reset clears map and insertion bits
    rst = 1'h1;
    @(negedge core_clk);
    rst = 1'h0;
    rd(CTRL8_ADDR[2], 8'h00);
    rd(MAP_ADDR[0], MAP_RST);
    $display("second reset test done");
    give_verdict();
  end
endmodule : dscp_priority_map_upper_bench
